// ===== slc_sleep_controller.sv
// Sleep mode controller: register, sleep sequencing, wake-up and clock gating
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
module slc_sleep_controller (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic [3:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [7:0]           reg_rdata,
  input  wire logic                 sleep_instr,
  input  wire slc_pkg::slc_wake_t   wake_req,
  input  wire slc_pkg::slc_standby_t run_in_standby,
  input  wire logic [1:0]           bod_active_cfg,
  input  wire logic                 bod_ready,
  input  wire logic                 main_osc_ready,
  input  wire logic                 ulp_used,
  input  wire logic                 debug_break,
  output logic                      cpu_run,
  output logic                      main_osc_en,
  output logic                      ulp_osc_en,
  output logic                      rtc_clk_en,
  output logic                      irq
);
  slc_pkg::slc_state_t state_reg;
  slc_pkg::slc_state_t state_next;
  slc_pkg::slc_wake_t  wake_s;
  logic [1:0] mode_reg;
  logic [1:0] mode_next;
  logic       enable_reg;
  logic       enable_next;
  logic [1:0] sleep_mode_reg;
  logic [1:0] sleep_mode_next;
  logic [slc_pkg::EVT_WIDTH-1:0] status_reg;
  logic [slc_pkg::EVT_WIDTH-1:0] status_next;
  logic [slc_pkg::EVT_WIDTH-1:0] mask_reg;
  logic [slc_pkg::EVT_WIDTH-1:0] mask_next;
  logic [slc_pkg::EVT_WIDTH-1:0] events;
  logic [7:0] rdata_next;
  logic       cpu_run_next;
  logic       main_osc_next;
  logic       ulp_next;
  logic       rtc_next;
  logic       irq_next;
  logic       bod_s;
  logic       osc_s;
  logic       dbg_s;
  logic       wake_ok;
  logic       timer_start;
  logic       timer_done;
  logic       bod_hold;
  logic       wr_ctrl;
  logic       wr_status;
  logic       wr_mask;

  // ----------------------------------------
  // Input synchronisers and wake timer
  // ----------------------------------------
  slc_sync #(
    .WIDTH (slc_pkg::WAKE_SRC_WIDTH)
  ) u_wake_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (wake_req),
    .sync_out (wake_s)
  );

  slc_sync #(
    .WIDTH (3)
  ) u_ctl_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({bod_ready, main_osc_ready, debug_break}),
    .sync_out ({bod_s, osc_s, dbg_s})
  );

  slc_wake_timer #(
    .CYCLES (slc_pkg::WAKE_CYCLES)
  ) u_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (timer_start),
    .done    (timer_done)
  );

  // ----------------------------------------
  // Wake qualification
  // ----------------------------------------
  always_comb begin
    wake_ok = 1'b0;
    if (wake_s.pin_change || wake_s.two_wire_match) begin
      wake_ok = 1'b1;
    end
    case (sleep_mode_reg)
      slc_pkg::MODE_IDLE: begin
        wake_ok = wake_ok || (|wake_s);
      end
      slc_pkg::MODE_STANDBY: begin
        wake_ok = wake_ok
          || (wake_s.serial_frame && run_in_standby.serial_frame)
          || (wake_s.touch_controller && run_in_standby.touch_controller)
          || ((wake_s.rtc_other || wake_s.periodic_interrupt_timer) && run_in_standby.rtc)
          || (wake_s.capture_timer && run_in_standby.capture_timer)
          || wake_s.voltage_level_monitor || wake_s.custom_logic;
      end
      slc_pkg::MODE_POWER_DOWN: begin
        wake_ok = wake_ok || wake_s.periodic_interrupt_timer
          || wake_s.voltage_level_monitor || wake_s.custom_logic;
      end
      default: begin
        wake_ok = wake_ok;
      end
    endcase
  end

  // ----------------------------------------
  // Sleep sequencer
  // ----------------------------------------
  always_comb begin
    state_next      = state_reg;
    sleep_mode_next = sleep_mode_reg;
    timer_start     = 1'b0;
    bod_hold        = 1'b0;
    events          = '0;
    case (state_reg)
      slc_pkg::ST_ACTIVE: begin
        if (sleep_instr && enable_reg && (mode_reg != slc_pkg::MODE_RESERVED)) begin
          state_next      = slc_pkg::ST_SLEEP;
          sleep_mode_next = mode_reg;
        end
      end
      slc_pkg::ST_SLEEP: begin
        if (wake_ok || dbg_s) begin
          events[slc_pkg::EVT_WAKE_IRQ]   = wake_ok;
          events[slc_pkg::EVT_WAKE_DEBUG] = dbg_s;
          if ((sleep_mode_reg == slc_pkg::MODE_IDLE) || (main_osc_en && osc_s)) begin
            state_next  = slc_pkg::ST_WAKE_COUNT;
            timer_start = 1'b1;
          end else begin
            state_next = slc_pkg::ST_OSC_WAIT;
          end
        end
      end
      slc_pkg::ST_OSC_WAIT: begin
        if (osc_s) begin
          state_next  = slc_pkg::ST_WAKE_COUNT;
          timer_start = 1'b1;
        end
      end
      slc_pkg::ST_WAKE_COUNT: begin
        if (timer_done) begin
          bod_hold = (bod_active_cfg == slc_pkg::BOD_WAIT_CFG) && !bod_s;
          events[slc_pkg::EVT_BOD_STRETCH] = bod_hold;
          state_next = bod_hold ? slc_pkg::ST_BOD_WAIT : slc_pkg::ST_ACTIVE;
        end
      end
      slc_pkg::ST_BOD_WAIT: begin
        if (bod_s) begin
          state_next = slc_pkg::ST_ACTIVE;
        end
      end
      default: begin
        state_next = slc_pkg::ST_ACTIVE;
      end
    endcase
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_comb begin
    wr_ctrl     = reg_wr && (reg_addr == slc_pkg::SLEEP_CONTROL_OFS);
    wr_status   = reg_wr && (reg_addr == slc_pkg::STATUS_OFS);
    wr_mask     = reg_wr && (reg_addr == slc_pkg::MASK_OFS);
    mode_next   = mode_reg;
    enable_next = enable_reg;
    mask_next   = mask_reg;
    if (wr_ctrl) begin
      mode_next   = reg_wdata[slc_pkg::MODE_MSB:slc_pkg::MODE_LSB];
      enable_next = reg_wdata[slc_pkg::ENABLE_BIT];
    end
    if (wr_mask) begin
      mask_next = reg_wdata[slc_pkg::EVT_WIDTH-1:0];
    end
    // Set wins over write-one-to-clear
    status_next = status_reg;
    if (wr_status) begin
      status_next = status_reg & ~reg_wdata[slc_pkg::EVT_WIDTH-1:0];
    end
    status_next = status_next | events;
    rdata_next  = 8'h00;
    if (reg_rd) begin
      if (reg_addr == slc_pkg::SLEEP_CONTROL_OFS) begin
        rdata_next = {5'h00, mode_reg, enable_reg};
      end else if (reg_addr == slc_pkg::STATUS_OFS) begin
        rdata_next = {5'h00, status_reg};
      end else if (reg_addr == slc_pkg::MASK_OFS) begin
        rdata_next = {5'h00, mask_reg};
      end else if (reg_addr == slc_pkg::STATE_OFS) begin
        rdata_next = {3'h0, sleep_mode_reg, state_reg};
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  // ----------------------------------------
  // Output decode
  // ----------------------------------------
  always_comb begin
    cpu_run_next  = (state_next == slc_pkg::ST_ACTIVE);
    main_osc_next = 1'b1;
    ulp_next      = 1'b1;
    rtc_next      = 1'b1;
    if (state_next == slc_pkg::ST_SLEEP) begin
      // Standby keeps clock if any peripheral runs
      if (sleep_mode_next == slc_pkg::MODE_STANDBY) begin
        main_osc_next = |run_in_standby;
        rtc_next      = run_in_standby.rtc;
      end else if (sleep_mode_next == slc_pkg::MODE_POWER_DOWN) begin
        main_osc_next = 1'b0;
        ulp_next      = ulp_used;
        rtc_next      = ulp_used;
      end
    end
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg      <= slc_pkg::ST_ACTIVE;
      sleep_mode_reg <= slc_pkg::MODE_IDLE;
      mode_reg       <= slc_pkg::SLEEP_CONTROL_RST[slc_pkg::MODE_MSB:slc_pkg::MODE_LSB];
      enable_reg     <= slc_pkg::SLEEP_CONTROL_RST[slc_pkg::ENABLE_BIT];
      status_reg     <= '0;
      mask_reg       <= '0;
      reg_rdata      <= 8'h00;
      cpu_run        <= 1'b1;
      main_osc_en    <= 1'b1;
      ulp_osc_en     <= 1'b1;
      rtc_clk_en     <= 1'b1;
      irq            <= 1'b0;
    end else begin
      state_reg      <= state_next;
      sleep_mode_reg <= sleep_mode_next;
      mode_reg       <= mode_next;
      enable_reg     <= enable_next;
      status_reg     <= status_next;
      mask_reg       <= mask_next;
      reg_rdata      <= rdata_next;
      cpu_run        <= cpu_run_next;
      main_osc_en    <= main_osc_next;
      ulp_osc_en     <= ulp_next;
      rtc_clk_en     <= rtc_next;
      irq            <= irq_next;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  wake_count_len_a: assert property (
    (state_reg == slc_pkg::ST_WAKE_COUNT) && ($past(state_reg) != slc_pkg::ST_WAKE_COUNT)
    |-> (state_reg == slc_pkg::ST_WAKE_COUNT) [*6] ##1 (state_reg != slc_pkg::ST_WAKE_COUNT))
    else $error("wake count not six cycles");

  idle_no_osc_a: assert property (
    (state_reg == slc_pkg::ST_SLEEP) && (sleep_mode_reg == slc_pkg::MODE_IDLE) && wake_ok
    |=> (state_reg == slc_pkg::ST_WAKE_COUNT))
    else $error("idle wake waited for oscillator");

  pin_wakes_standby_a: assert property (
    (state_reg == slc_pkg::ST_SLEEP) && (sleep_mode_reg == slc_pkg::MODE_STANDBY)
    && wake_s.pin_change |=> state_reg inside {slc_pkg::ST_OSC_WAIT, slc_pkg::ST_WAKE_COUNT})
    else $error("pin change did not wake standby");

  power_down_mode_rtc_block_a: assert property (
    (state_reg == slc_pkg::ST_SLEEP) && (sleep_mode_reg == slc_pkg::MODE_POWER_DOWN)
    && !dbg_s && (wake_s == slc_wake_only_rtc()) |=> (state_reg == slc_pkg::ST_SLEEP))
    else $error("counter interrupt woke power-down");

  power_down_mode_clock_off_a: assert property (
    (state_reg == slc_pkg::ST_SLEEP) && (sleep_mode_reg == slc_pkg::MODE_POWER_DOWN)
    |-> !main_osc_en && !cpu_run)
    else $error("main clock running in power-down");

  bod_hold_a: assert property (
    (state_reg == slc_pkg::ST_WAKE_COUNT) && timer_done
    && (bod_active_cfg == slc_pkg::BOD_WAIT_CFG) && !bod_s
    |=> (state_reg == slc_pkg::ST_BOD_WAIT) && !cpu_run)
    else $error("execution resumed before detector ready");

  debug_wake_a: assert property (
    (state_reg == slc_pkg::ST_SLEEP) && dbg_s |=> (state_reg != slc_pkg::ST_SLEEP))
    else $error("debug break did not wake");

  no_enable_stay_a: assert property (
    (state_reg == slc_pkg::ST_ACTIVE) && sleep_instr
    && (!enable_reg || (mode_reg == slc_pkg::MODE_RESERVED))
    |=> (state_reg == slc_pkg::ST_ACTIVE) && cpu_run)
    else $error("slept without enable or valid mode");

  ctrl_read_back_a: assert property (
    reg_rd && (reg_addr == slc_pkg::SLEEP_CONTROL_OFS) && !reg_wr
    |=> (reg_rdata == {5'h00, $past(mode_reg), $past(enable_reg)}))
    else $error("control read back wrong");

  idle_wake_c: cover property (
    (state_reg == slc_pkg::ST_SLEEP) && (sleep_mode_reg == slc_pkg::MODE_IDLE) && wake_ok);
  power_down_mode_wake_c: cover property (
    (state_reg == slc_pkg::ST_OSC_WAIT) && (sleep_mode_reg == slc_pkg::MODE_POWER_DOWN));
  bod_wait_c: cover property (state_reg == slc_pkg::ST_BOD_WAIT);

  function automatic slc_pkg::slc_wake_t slc_wake_only_rtc();
    slc_pkg::slc_wake_t w;
    w = '0;
    w.rtc_other = 1'b1;
    return w;
  endfunction
endmodule // slc_sleep_controller

// ===== slc_pkg.sv
// Package of constants, types and states for the sleep mode controller
package slc_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] SLEEP_CONTROL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS        = 4'h1;
  localparam logic [3:0] MASK_OFS          = 4'h2;
  localparam logic [3:0] STATE_OFS         = 4'h3;
  localparam logic [7:0] SLEEP_CONTROL_RST = 8'h00;
  localparam int         ENABLE_BIT        = 0;
  localparam int         MODE_LSB          = 1;
  localparam int         MODE_MSB          = 2;
  localparam int         EVT_WIDTH         = 3;
  localparam int         EVT_WAKE_IRQ      = 0;
  localparam int         EVT_WAKE_DEBUG    = 1;
  localparam int         EVT_BOD_STRETCH   = 2;

  // ----------------------------------------
  // Modes and timing
  // ----------------------------------------
  localparam logic [1:0] MODE_IDLE       = 2'h0;
  localparam logic [1:0] MODE_STANDBY    = 2'h1;
  localparam logic [1:0] MODE_POWER_DOWN = 2'h2;
  localparam logic [1:0] MODE_RESERVED   = 2'h3;
  localparam logic [1:0] BOD_WAIT_CFG    = 2'h3;
  localparam int         WAKE_CYCLES     = 6;
  localparam int         WAKE_SRC_WIDTH  = 10;

  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_SLEEP,
    ST_OSC_WAIT,
    ST_WAKE_COUNT,
    ST_BOD_WAIT
  } slc_state_t;

  // Synchronised wake-up requests
  typedef struct packed {
    logic pin_change;
    logic two_wire_match;
    logic serial_frame;
    logic touch_controller;
    logic rtc_other;
    logic periodic_interrupt_timer;
    logic capture_timer;
    logic voltage_level_monitor;
    logic custom_logic;
    logic other_irq;
  } slc_wake_t;

  // Per-peripheral run_in_standby settings
  typedef struct packed {
    logic serial_frame;
    logic touch_controller;
    logic rtc;
    logic capture_timer;
  } slc_standby_t;

endpackage

// ===== slc_sync.sv
// Two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/1ns
module slc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // ----------------------------------------
  // Per-bit stages
  // ----------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        meta_reg[i] <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        meta_reg[i] <= async_in[i];
        sync_out[i] <= meta_reg[i];
      end
    end
  end
endmodule // slc_sync

// ===== slc_wake_timer.sv
// Down counter that times the wake-up latency
`timescale 1ns/1ns
module slc_wake_timer #(
  parameter int CYCLES = slc_pkg::WAKE_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic start,
  output logic      done
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);
  localparam logic [CW-1:0] ONE  = CW'(1);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  // ----------------------------------------
  // Count
  // ----------------------------------------
  always_comb begin
    cnt_next = cnt_reg;
    if (start) begin
      cnt_next = LOAD;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - ONE;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign done = (cnt_reg == ONE);
endmodule // slc_wake_timer

// ===== slc_osc_bod_model.sv
// Main oscillator and brown-out detector model at the far side of the controller
`timescale 1ns/1ns
module slc_osc_bod_model #(
  parameter int OSC_DLY = 5,
  parameter int BOD_DLY = 24
) (
  input  wire logic clk,
  input  wire logic main_osc_en,
  input  wire logic cpu_run,
  input  wire logic bod_slow,
  output logic      main_osc_ready,
  output logic      bod_ready
);
  int osc_cnt = 0;
  int bod_cnt = 0;

  always @(posedge clk) begin
    if (!main_osc_en) begin
      osc_cnt <= 0;
    end else if (osc_cnt < OSC_DLY) begin
      osc_cnt <= osc_cnt + 1;
    end
    bod_cnt <= cpu_run ? 0 : bod_cnt + 1;
  end

  assign main_osc_ready = main_osc_en && (osc_cnt >= OSC_DLY);
  assign bod_ready = !bod_slow || (bod_cnt >= BOD_DLY);
endmodule // slc_osc_bod_model

// ===== sleep_mode_controller_tb.sv
// Self-checking testbench of the sleep mode controller
`timescale 1ns/1ns
module sleep_mode_controller_tb;
  // Two sync stages and one decision cycle ahead of the count
  localparam int IDLE_LAT = slc_pkg::WAKE_CYCLES + 3;
  localparam int OSC_DLY  = 5;

  logic                 clk            = 1'b0;
  logic                 reset_n        = 1'b0;
  logic [3:0]           reg_addr       = 4'h0;
  logic [7:0]           reg_wdata      = 8'h00;
  logic                 reg_wr         = 1'b0;
  logic                 reg_rd         = 1'b0;
  logic [7:0]           reg_rdata;
  logic                 sleep_instr    = 1'b0;
  slc_pkg::slc_wake_t   wake_req       = '0;
  slc_pkg::slc_standby_t run_in_standby = '0;
  logic [1:0]           bod_active_cfg = 2'h0;
  logic                 bod_ready;
  logic                 main_osc_ready;
  logic                 ulp_used       = 1'b0;
  logic                 debug_break    = 1'b0;
  logic                 bod_slow       = 1'b0;
  logic                 cpu_run;
  logic                 main_osc_en;
  logic                 ulp_osc_en;
  logic                 rtc_clk_en;
  logic                 irq;
  int                   mismatches     = 0;
  int                   n_compared     = 0;

  always #25 clk = ~clk;

  slc_sleep_controller u_dut (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_instr(sleep_instr),
    .wake_req(wake_req), .run_in_standby(run_in_standby), .bod_active_cfg(bod_active_cfg),
    .bod_ready(bod_ready), .main_osc_ready(main_osc_ready), .ulp_used(ulp_used),
    .debug_break(debug_break), .cpu_run(cpu_run), .main_osc_en(main_osc_en),
    .ulp_osc_en(ulp_osc_en), .rtc_clk_en(rtc_clk_en), .irq(irq)
  );

  slc_osc_bod_model #(.OSC_DLY(OSC_DLY), .BOD_DLY(24)) u_far (
    .clk(clk), .main_osc_en(main_osc_en), .cpu_run(cpu_run), .bod_slow(bod_slow),
    .main_osc_ready(main_osc_ready), .bod_ready(bod_ready)
  );

  // ----------------------------------------
  // Compare, bus, sleep and wake tasks
  // ----------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic sleep_enter(input logic [7:0] ctrl);
    reg_write(slc_pkg::SLEEP_CONTROL_OFS, ctrl);
    @(posedge clk);
    sleep_instr <= 1'b1;
    @(posedge clk);
    sleep_instr <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic wait_run(input int max, output int lat);
    lat = 0;
    while (lat < max) begin
      @(posedge clk);
      #1 lat++;
      if (cpu_run === 1'b1) break;
    end
  endtask

  task automatic wake_once(input logic [9:0] src, input int max, output int lat);
    @(posedge clk);
    wake_req <= slc_pkg::slc_wake_t'(src);
    wait_run(max, lat);
    @(posedge clk);
    wake_req <= '0;
    repeat (4) @(posedge clk);
  endtask

  function automatic logic wake_expect(input int m, input int b, input int r);
    logic [9:0] allow;
    allow = (m == 0) ? 10'h3FF : (m == 2) ? 10'h316 : (r != 0) ? 10'h3FE : 10'h306;
    return allow[b];
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_registers();
    logic [7:0] d;
    reg_read(slc_pkg::SLEEP_CONTROL_OFS, d);
    chk_byte(d, 8'h00);
    reg_write(slc_pkg::SLEEP_CONTROL_OFS, 8'hFF);
    reg_read(slc_pkg::SLEEP_CONTROL_OFS, d);
    chk_byte(d, 8'h07);
    reg_read(4'hF, d);
    chk_byte(d, 8'h00);
  endtask

  task automatic test_refused();
    sleep_enter(8'h04);
    chk_bit(cpu_run, 1'b1);
    sleep_enter(8'h07);
    chk_bit(cpu_run, 1'b1);
  endtask

  task automatic test_wake_table();
    int   lat;
    logic exp;
    logic osc_on;
    for (int mi = 0; mi < 3; mi++) begin
      for (int r = 0; r < 2; r++) begin
        for (int b = 0; b < 10; b++) begin
          run_in_standby <= {4{r[0]}};
          ulp_used       <= r[0];
          sleep_enter(8'(mi * 2 + 1));
          chk_bit(cpu_run, 1'b0);
          osc_on = main_osc_en;
          if (mi == 0) chk_bit(main_osc_en, 1'b1);
          if (mi == 1) chk_bit(main_osc_en, r[0]);
          if (mi == 2) chk_bit(main_osc_en, 1'b0);
          if (mi == 2) chk_bit(ulp_osc_en, r[0]);
          if (mi == 0) chk_bit(rtc_clk_en, 1'b1);
          if (mi != 0) chk_bit(rtc_clk_en, r[0]);
          exp = wake_expect(mi, b, r);
          wake_once(10'h001 << b, 30, lat);
          chk_bit(cpu_run, exp);
          if (exp && osc_on) chk_byte(8'(lat), 8'(IDLE_LAT));
          if (exp && !osc_on) chk_bit(lat >= IDLE_LAT + OSC_DLY, 1'b1);
          if (!exp) begin
            @(posedge clk);
            debug_break <= 1'b1;
            wait_run(40, lat);
            chk_bit(cpu_run, 1'b1);
            @(posedge clk);
            debug_break <= 1'b0;
            repeat (4) @(posedge clk);
          end
        end
      end
    end
  endtask

  task automatic test_bod();
    logic [7:0] d;
    int lat;
    bod_active_cfg <= slc_pkg::BOD_WAIT_CFG;
    sleep_enter(8'h01);
    wake_once(10'h200, 40, lat);
    chk_byte(8'(lat), 8'(IDLE_LAT));
    reg_write(slc_pkg::STATUS_OFS, 8'h07);
    bod_slow <= 1'b1;
    sleep_enter(8'h01);
    wake_once(10'h200, 60, lat);
    chk_bit(lat >= 20, 1'b1);
    chk_bit(cpu_run, 1'b1);
    reg_read(slc_pkg::STATUS_OFS, d);
    chk_byte(d, 8'h05);
    bod_slow       <= 1'b0;
    bod_active_cfg <= 2'h0;
  endtask

  task automatic test_irq();
    logic [7:0] d;
    int         lat;
    reg_write(slc_pkg::MASK_OFS, 8'h00);
    reg_write(slc_pkg::STATUS_OFS, 8'h07);
    sleep_enter(8'h01);
    wake_once(10'h200, 40, lat);
    reg_read(slc_pkg::STATUS_OFS, d);
    chk_byte(d, 8'h01);
    chk_bit(irq, 1'b0);
    reg_write(slc_pkg::MASK_OFS, 8'h01);
    repeat (2) @(posedge clk);
    chk_bit(irq, 1'b1);
    reg_write(slc_pkg::STATUS_OFS, 8'h01);
    repeat (2) @(posedge clk);
    chk_bit(irq, 1'b0);
  endtask

  task automatic test_reset_in_sleep();
    logic [7:0] d;
    sleep_enter(8'h05);
    chk_bit(cpu_run, 1'b0);
    reg_read(slc_pkg::STATE_OFS, d);
    chk_byte(d, 8'h11);
    @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    #1 chk_bit(cpu_run, 1'b1);
    @(posedge clk);
    reset_n <= 1'b1;
    reg_read(slc_pkg::SLEEP_CONTROL_OFS, d);
    chk_byte(d, 8'h00);
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    test_registers();
    test_refused();
    test_wake_table();
    test_bod();
    test_irq();
    test_reset_in_sleep();
    end_of_test();
  end

  initial begin
    #1_000_000;
    mismatches++;
    end_of_test();
  end
endmodule // sleep_mode_controller_tb
